// ### hdl/sdcs_map.svh
// constants for the command spacing logic of the memory device
// assumes one memory clock, the controller sampled on its rising edge
`ifndef SDCS_MAP_SVH
`define SDCS_MAP_SVH

// clock and nanosecond spacings, in picoseconds
`define SDCS_CLK_PERIOD_PS       50000
`define SDCS_PRECHARGE_PERIOD_PS 15000
`define SDCS_RP_CYCLES \
    ((`SDCS_PRECHARGE_PERIOD_PS + `SDCS_CLK_PERIOD_PS - 1) / `SDCS_CLK_PERIOD_PS)

// spacings in clock edges
`define SDCS_WTR_CYCLES      2
`define SDCS_XP_CYCLES       2
`define SDCS_CKE_MIN_EDGES   2'h3

// mode register load fields and the write autoprecharge address bit
`define SDCS_BA_MR           3'h0
`define SDCS_BA_EMR          3'h1
`define SDCS_WR_LSB          9
`define SDCS_WR_MSB          11
`define SDCS_WR_OFFSET       1
`define SDCS_WR_CODE_RST     3'h3
`define SDCS_STROBE_BIT      10
`define SDCS_STROBE_SE_RST   1'h0
`define SDCS_AP_BIT          10

// violation vector bits
`define SDCS_VIOL_DAL        0
`define SDCS_VIOL_WTR        1
`define SDCS_VIOL_XP         2
`define SDCS_VIOL_CKE        3

`endif

// ### hdl/sdcs_pkg.sv
// types for the command spacing logic
// assumes nothing beyond the map header
package sdcs_pkg;
    // values equal the ras/cas/we pin pattern
    typedef enum logic [2:0] {
        SDCS_CMD_MRS = 3'h0,
        SDCS_CMD_REF = 3'h1,
        SDCS_CMD_PRE = 3'h2,
        SDCS_CMD_ACT = 3'h3,
        SDCS_CMD_WR  = 3'h4,
        SDCS_CMD_RD  = 3'h5,
        SDCS_CMD_RSV = 3'h6,
        SDCS_CMD_NOP = 3'h7
    } sdcs_cmd_t;

    typedef enum logic [1:0] {
        SDCS_PWR_ACTIVE = 2'h0,
        SDCS_PWR_DOWN   = 2'h1,
        SDCS_PWR_EXIT   = 2'h3
    } sdcs_pwr_t;
endpackage

// ### hdl/sdcs_gap_timer.sv
// edge counter that holds a spacing window open
// assumes load values of at least one edge
`timescale 1ns/1ps
module sdcs_gap_timer #(
    parameter int TIMER_W = 5
) (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // window control
    input  wire logic               load_in,
    input  wire logic [TIMER_W-1:0] count_in,
    output logic                    busy_out
);
    if (TIMER_W < 2) begin : g_bad
        $error("sdcs_gap_timer: timer too narrow");
    end

    logic [TIMER_W-1:0] count_reg;

    // counts edges, not time, so jitter never shortens it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else if (load_in) begin
            count_reg <= count_in - TIMER_W'(1);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - TIMER_W'(1);
        end
    end

    assign busy_out = (count_reg != '0);
endmodule

// ### hdl/sdcs_spacing_core.sv
// device side command spacing, power-down exit and mode tracking
// assumes controller commands on the same clock as CORE_CLK_IN
`timescale 1ns/1ps
`include "sdcs_map.svh"
module sdcs_spacing_core #(
    parameter int NUM_BANKS = 8,
    parameter int BANK_W    = 3,
    parameter int ADDR_W    = 14,
    parameter int TIMER_W   = 5
) (
    // clock and reset
    input  wire logic                CORE_CLK_IN,
    input  wire logic                RST_IN,
    // command pins
    input  wire logic                CKE_IN,
    input  wire logic                CS_N_IN,
    input  wire logic                RAS_N_IN,
    input  wire logic                CAS_N_IN,
    input  wire logic                WE_N_IN,
    input  wire logic [BANK_W-1:0]   BA_IN,
    input  wire logic [ADDR_W-1:0]   ADDR_IN,
    input  wire logic                DATA_TIMING_BAD_IN,
    // command results
    output logic                     CMD_ACCEPT_OUT,
    output sdcs_pkg::sdcs_cmd_t      CMD_CODE_OUT,
    output logic [3:0]               VIOLATION_OUT,
    output logic                     DATA_SUSPECT_OUT,
    // state
    output logic                     POWERED_DOWN_OUT,
    output logic                     STROBE_DIFF_EN_OUT,
    output logic                     STROBE_SE_EN_OUT
);
    import sdcs_pkg::*;

    if (NUM_BANKS != (1 << BANK_W) || ADDR_W <= `SDCS_WR_MSB || TIMER_W < 5) begin : g_bad
        $error("sdcs_spacing_core: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic sdcs_cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n,
                                             input logic live);
        if (cs_n || !live) begin
            return SDCS_CMD_NOP;
        end
        return sdcs_cmd_t'({ras_n, cas_n, we_n});
    endfunction

    logic                cke_prev_reg;
    logic [1:0]          cke_run_reg;
    sdcs_pwr_t           pwr_reg;
    sdcs_pwr_t           pwr_next;
    sdcs_cmd_t           cmd;
    logic                cke_glitch;
    logic                exit_edge;
    logic                xp_busy;
    logic                wtr_busy;
    logic [NUM_BANKS-1:0] dal_busy;
    logic [NUM_BANKS-1:0] dirty_reg;
    logic [2:0]          wr_code_reg;
    logic                strobe_se_reg;
    logic                strobe_bit;
    logic                act_xp_bad;
    logic                act_dal_bad;
    logic                rd_wtr_bad;
    logic [TIMER_W-1:0]  dal_total;

    // commands count only while clock enable is high on both edges
    assign cmd        = cmd_decode(CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, cke_prev_reg & CKE_IN);
    assign cke_glitch = (CKE_IN != cke_prev_reg) && (cke_run_reg < `SDCS_CKE_MIN_EDGES);
    assign exit_edge  = (pwr_reg == SDCS_PWR_DOWN) && !cke_prev_reg && CKE_IN;
    assign strobe_bit = ADDR_IN[`SDCS_STROBE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // clock enable registration and power state

    // run length of the registered level
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cke_prev_reg <= 1'h0;
            cke_run_reg  <= `SDCS_CKE_MIN_EDGES;
        end else if (CKE_IN != cke_prev_reg) begin
            cke_prev_reg <= CKE_IN;
            cke_run_reg  <= 2'h1;
        end else if (cke_run_reg != `SDCS_CKE_MIN_EDGES) begin
            cke_run_reg  <= cke_run_reg + 2'h1;
        end
    end

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            SDCS_PWR_ACTIVE: begin
                if (cke_prev_reg && !CKE_IN) begin
                    pwr_next = SDCS_PWR_DOWN;
                end
            end
            SDCS_PWR_DOWN: begin
                if (exit_edge) begin
                    pwr_next = SDCS_PWR_EXIT;
                end
            end
            SDCS_PWR_EXIT: begin
                // a drop inside the exit window must not strand the part in active
                if (cke_prev_reg && !CKE_IN) begin
                    pwr_next = SDCS_PWR_DOWN;
                end else if (!xp_busy) begin
                    pwr_next = SDCS_PWR_ACTIVE;
                end
            end
            default: begin
                pwr_next = SDCS_PWR_DOWN;
            end
        endcase
    end

    // clock enable is low out of reset, so the part starts powered down
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pwr_reg <= SDCS_PWR_DOWN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // spacing windows

    // exit at edge Tm frees activate at Tm+2
    sdcs_gap_timer #(.TIMER_W(TIMER_W)) u_xp (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RST_IN),
        .load_in  (exit_edge),
        .count_in (TIMER_W'(`SDCS_XP_CYCLES)),
        .busy_out (xp_busy)
    );

    // write to read turnaround is a fixed edge count
    sdcs_gap_timer #(.TIMER_W(TIMER_W)) u_wtr (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RST_IN),
        .load_in  (cmd == SDCS_CMD_WR),
        .count_in (TIMER_W'(`SDCS_WTR_CYCLES)),
        .busy_out (wtr_busy)
    );

    // write recovery plus rounded-up precharge cycles
    assign dal_total = TIMER_W'(wr_code_reg) + TIMER_W'(`SDCS_WR_OFFSET)
                     + TIMER_W'(`SDCS_RP_CYCLES);

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic bank_hit;
        assign bank_hit = (BA_IN == BANK_W'(b));

        sdcs_gap_timer #(.TIMER_W(TIMER_W)) u_dal (
            .clk_in   (CORE_CLK_IN),
            .rst_in   (RST_IN),
            .load_in  (cmd == SDCS_CMD_WR && ADDR_IN[`SDCS_AP_BIT] && bank_hit),
            .count_in (dal_total),
            .busy_out (dal_busy[b])
        );

        // bad data timing marks the bank; a clean write clears it
        always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                dirty_reg[b] <= 1'h0;
            end else if (cmd == SDCS_CMD_WR && bank_hit) begin
                dirty_reg[b] <= DATA_TIMING_BAD_IN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode fields

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wr_code_reg   <= `SDCS_WR_CODE_RST;
            strobe_se_reg <= `SDCS_STROBE_SE_RST;
        end else if (cmd == SDCS_CMD_MRS) begin
            if (BA_IN == `SDCS_BA_MR) begin
                wr_code_reg <= ADDR_IN[`SDCS_WR_MSB:`SDCS_WR_LSB];
            end
            if (BA_IN == `SDCS_BA_EMR) begin
                strobe_se_reg <= strobe_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command results

    assign act_xp_bad  = (cmd == SDCS_CMD_ACT) && xp_busy;
    assign act_dal_bad = (cmd == SDCS_CMD_ACT) && dal_busy[BA_IN];
    assign rd_wtr_bad  = (cmd == SDCS_CMD_RD) && wtr_busy;

    // a refused command still shows its code, so the bench sees what was refused
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CMD_ACCEPT_OUT   <= 1'h0;
            CMD_CODE_OUT     <= SDCS_CMD_NOP;
            VIOLATION_OUT    <= 4'h0;
            DATA_SUSPECT_OUT <= 1'h0;
        end else begin
            CMD_ACCEPT_OUT   <= (cmd != SDCS_CMD_NOP) && !act_xp_bad && !act_dal_bad
                                && !rd_wtr_bad;
            CMD_CODE_OUT     <= cmd;
            VIOLATION_OUT    <= {cke_glitch, act_xp_bad, rd_wtr_bad, act_dal_bad};
            DATA_SUSPECT_OUT <= (cmd == SDCS_CMD_RD) && dirty_reg[BA_IN];
        end
    end

    assign POWERED_DOWN_OUT   = (pwr_reg == SDCS_PWR_DOWN);
    assign STROBE_SE_EN_OUT   = strobe_se_reg;
    assign STROBE_DIFF_EN_OUT = !strobe_se_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [BANK_W-1:0]  wap_bank_reg;
    logic [TIMER_W-1:0] wap_total_reg;
    logic [TIMER_W-1:0] since_wap_reg;

    // edges since the latest write with autoprecharge, saturating
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wap_bank_reg  <= '0;
            wap_total_reg <= '0;
            since_wap_reg <= '1;
        end else if (cmd == SDCS_CMD_WR && ADDR_IN[`SDCS_AP_BIT]) begin
            wap_bank_reg  <= BA_IN;
            wap_total_reg <= dal_total;
            since_wap_reg <= TIMER_W'(1);
        end else if (since_wap_reg != '1) begin
            since_wap_reg <= since_wap_reg + TIMER_W'(1);
        end
    end

    chk_xp_exit_gap: assert property (
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        exit_edge |=> xp_busy ##1 !xp_busy)
        else $error("activate window after power-down exit is not two edges");

    chk_dal_early_act: assert property (
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (cmd == SDCS_CMD_ACT && BA_IN == wap_bank_reg && since_wap_reg < wap_total_reg)
        |=> !CMD_ACCEPT_OUT && VIOLATION_OUT[`SDCS_VIOL_DAL])
        else $error("activate accepted inside autoprecharge window");

    chk_dal_late_act: assert property (
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (cmd == SDCS_CMD_ACT && BA_IN == wap_bank_reg && since_wap_reg >= wap_total_reg
         && !xp_busy) |=> CMD_ACCEPT_OUT)
        else $error("activate refused after autoprecharge window closed");

    chk_wtr_back_read: assert property (
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (cmd == SDCS_CMD_WR) ##1 (cmd == SDCS_CMD_RD)
        |=> !CMD_ACCEPT_OUT && VIOLATION_OUT[`SDCS_VIOL_WTR])
        else $error("read accepted one edge after write");

    chk_strobe_mode_sel: assert property (
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (cmd == SDCS_CMD_MRS && BA_IN == `SDCS_BA_EMR)
        |=> STROBE_SE_EN_OUT == $past(strobe_bit) && STROBE_DIFF_EN_OUT == !$past(strobe_bit))
        else $error("strobe style does not follow mode bit");

    chk_cke_short_pulse: assert property (
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CKE_IN != cke_prev_reg) ##1 (CKE_IN != cke_prev_reg)
        |=> VIOLATION_OUT[`SDCS_VIOL_CKE])
        else $error("short clock enable pulse not flagged");
endmodule

// ### tb/sdcs_ctrl_model.sv
// controller model that drives the command pins of the spacing core
// assumes one issue call per clock, made from the bench's main process
`timescale 1ns/1ps
module sdcs_ctrl_model
    import sdcs_pkg::*;
(
    // clock
    input  wire logic         clk_in,
    // command pins
    output logic              cke_out,
    output logic              cs_n_out,
    output logic              ras_n_out,
    output logic              cas_n_out,
    output logic              we_n_out,
    output logic [2:0]        ba_out,
    output logic [13:0]       addr_out,
    output logic              bad_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle pins until the first command; the memory clock rate never changes here
    initial begin
        cke_out = 1'h0;
        cs_n_out = 1'h1;
        {ras_n_out, cas_n_out, we_n_out} = 3'h7;
        ba_out = 3'h0;
        addr_out = 14'h0;
        bad_out = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one command per falling edge, held until the next one
    // spacing is the caller's: it counts whole rising edges and breaks them on purpose
    task automatic issue(input logic k, input sdcs_cmd_t c, input logic [2:0] b,
                         input logic [13:0] a, input logic bd);
        @(negedge clk_in);
        cke_out = k;
        cs_n_out = 1'h0;
        {ras_n_out, cas_n_out, we_n_out} = c;
        ba_out = b;
        addr_out = a;
        bad_out = bd;
        @(posedge clk_in);
        #1;
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the command spacing core
// assumes the controller model in sdcs_ctrl_model and the map header
`timescale 1ns/1ps
`include "sdcs_map.svh"
module tb;
    import sdcs_pkg::*;
    logic        clk;
    logic        rst;
    logic        cke, cs_n, ras_n, cas_n, we_n, bad;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic        acc, sus, pd, sdiff, sse;
    logic [3:0]  viol;
    sdcs_cmd_t   code;
    int          err_total = 0;
    int          n_compared = 0;
    logic [31:0] rng = 32'h00017da9;
    logic [7:0]  dirty;
    sdcs_cmd_t   tbl [5] = '{SDCS_CMD_WR, SDCS_CMD_RD, SDCS_CMD_PRE, SDCS_CMD_REF, SDCS_CMD_RSV};

    sdcs_ctrl_model ctl (.clk_in(clk), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .addr_out(addr), .bad_out(bad));
    sdcs_spacing_core dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CKE_IN(cke), .CS_N_IN(cs_n),
        .RAS_N_IN(ras_n), .CAS_N_IN(cas_n), .WE_N_IN(we_n), .BA_IN(ba), .ADDR_IN(addr),
        .DATA_TIMING_BAD_IN(bad), .CMD_ACCEPT_OUT(acc), .CMD_CODE_OUT(code),
        .VIOLATION_OUT(viol), .DATA_SUSPECT_OUT(sus), .POWERED_DOWN_OUT(pd),
        .STROBE_DIFF_EN_OUT(sdiff), .STROBE_SE_EN_OUT(sse));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // whole edges: write recovery plus rounded-up precharge
    function automatic int dal_edges(input int f);
        return f + 1 + `SDCS_RP_CYCLES;
    endfunction

    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic op(input sdcs_cmd_t c, input logic [2:0] b, input logic [13:0] a,
                      input logic bd, input logic ea, input logic [3:0] ev, input logic es);
        ctl.issue(1'h1, c, b, a, bd);
        chk("accept", {3'h0, ea}, {3'h0, acc});
        chk("code", {1'h0, c}, {1'h0, code});
        chk("violation", ev, viol);
        chk("suspect", {3'h0, es}, {3'h0, sus});
    endtask

    // x as expected power state means do not look
    task automatic cke_step(input logic k, input logic [3:0] ev, input logic epd);
        ctl.issue(k, SDCS_CMD_NOP, 3'h0, 14'h0, 1'h0);
        chk("cke_violation", ev, viol);
        chk("code_gated", {1'h0, SDCS_CMD_NOP}, {1'h0, code});
        if (epd !== 1'bx) chk("powered_down", {3'h0, epd}, {3'h0, pd});
    endtask

    task automatic summarize();
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic [2:0] b;
        sdcs_cmd_t c;
        rst = 1'h1;
        repeat (12) @(posedge clk);
        #1;
        chk("reset_pd", 4'h1, {3'h0, pd});
        chk("reset_diff", 4'h1, {3'h0, sdiff});
        chk("reset_se", 4'h0, {3'h0, sse});
        @(negedge clk);
        rst = 1'h0;
        cke_step(1'h0, 4'h0, 1'h1);
        cke_step(1'h0, 4'h0, 1'h1);
        cke_step(1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_ACT, 3'h0, 14'h0, 1'h0, 1'h0, 4'h4, 1'h0);
        op(SDCS_CMD_ACT, 3'h0, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_WR, 3'h1, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_RD, 3'h1, 14'h0, 1'h0, 1'h0, 4'h2, 1'h0);
        op(SDCS_CMD_RD, 3'h1, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_WR, 3'h3, 14'h0, 1'h1, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_PRE, 3'h3, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_RD, 3'h3, 14'h0, 1'h0, 1'h1, 4'h0, 1'h1);
        op(SDCS_CMD_RD, 3'h5, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_WR, 3'h3, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_PRE, 3'h3, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_RD, 3'h3, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        op(SDCS_CMD_MRS, `SDCS_BA_EMR, 14'h0400, 1'h0, 1'h1, 4'h0, 1'h0);
        chk("strobe_diff", 4'h0, {3'h0, sdiff});
        chk("strobe_se", 4'h1, {3'h0, sse});
        op(SDCS_CMD_MRS, `SDCS_BA_EMR, 14'h0000, 1'h0, 1'h1, 4'h0, 1'h0);
        chk("strobe_diff", 4'h1, {3'h0, sdiff});
        chk("strobe_se", 4'h0, {3'h0, sse});
        // every write recovery code, with activates to the neighbouring bank accepted inside the window
        for (int f = 0; f < 8; f++) begin
            n = dal_edges(f);
            rng = xs(rng);
            b = rng[2:0];
            op(SDCS_CMD_MRS, `SDCS_BA_MR, 14'(f << `SDCS_WR_LSB),
               1'h0, 1'h1, 4'h0, 1'h0);
            op(SDCS_CMD_WR, b, 14'h0400, 1'h0, 1'h1, 4'h0, 1'h0);
            for (int k = 1; k < n - 1; k++) begin
                op(SDCS_CMD_ACT, b ^ 3'h1, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
            end
            op(SDCS_CMD_ACT, b, 14'h0, 1'h0, 1'h0, 4'h1, 1'h0);
            op(SDCS_CMD_ACT, b, 14'h0, 1'h0, 1'h1, 4'h0, 1'h0);
        end
        dirty = 8'h0;
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            c = tbl[rng[31:8] % 5];
            b = rng[2:0];
            op(c, b, rng[17:4], rng[3], 1'h1, 4'h0, (c == SDCS_CMD_RD) && dirty[b]);
            if (c == SDCS_CMD_WR) dirty[b] = rng[3];
            op(SDCS_CMD_PRE, b, rng[31:18], 1'h0, 1'h1, 4'h0, 1'h0);
        end
        cke_step(1'h0, 4'h0, 1'h1);
        cke_step(1'h0, 4'h0, 1'h1);
        cke_step(1'h0, 4'h0, 1'h1);
        cke_step(1'h1, 4'h0, 1'h0);
        cke_step(1'h1, 4'h0, 1'h0);
        cke_step(1'h1, 4'h0, 1'h0);
        cke_step(1'h0, 4'h0, 1'h1);
        cke_step(1'h1, 4'h8, 1'h0);
        summarize();
    end
endmodule
